//--- rtl/flash_cmd_pkg.sv
// Constants, table contents and state types for the reset / unique-ID /
// parameter-table command slice and its controller.
// Assumes both ends run on the same 25 MHz system clock.
`default_nettype none
package flash_cmd_pkg;

    localparam logic [7:0] OP_RESET_ARM = 8'h66;
    localparam logic [7:0] OP_RESET_EXEC = 8'h99;
    localparam logic [7:0] OP_NOP = 8'h00;
    localparam logic [7:0] OP_UID_READ = 8'h4B;
    localparam logic [7:0] OP_TABLE_READ = 8'h5A;

    localparam int UID_DUMMY_BYTES = 4;
    localparam int TBL_ADDR_BYTES = 3;
    localparam int TBL_DUMMY_BYTES = 1;
    localparam int UID_BITS = 128;
    localparam int TBL_BYTES = 24;

    localparam logic [7:0] TBL_MFR_LOC = 8'h10;
    localparam logic [7:0] TBL_BLANK = 8'hFF;
    // Arbitrary neutral values, not tied to any real part
    localparam logic [7:0] MFR_CODE_DEFAULT = 8'hA5;
    localparam logic [127:0] UNIQUE_ID_DEFAULT = 128'h0123456789ABCDEF_FEDCBA9876543210;

    // Header area of the parameter table; the manufacturer slot is patched at run time
    localparam logic [7:0] TBL_ROM [0:23] = '{
        8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01, 8'hFF,
        8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hFF,
        8'h00, 8'h00, 8'h01, 8'h03, 8'h90, 8'h00, 8'h00, 8'hFF
    };

    localparam int CLK_NS = 40;
    localparam int SCLK_HALF_NS = 80;
    localparam int CS_HIGH_NS = 80;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int CS_GAP_CYC = (CS_HIGH_NS + CLK_NS - 1) / CLK_NS;

    typedef enum {DS_OPCODE, DS_ADDR, DS_DUMMY, DS_UID, DS_TABLE, DS_SKIP} dev_state_t;
    typedef enum {HS_IDLE, HS_FRAME, HS_GAP} host_state_t;

endpackage
`default_nettype wire

//--- rtl/flash_link_if.sv
// Serial link between the flash controller and the flash command slice.
// Assumes the testbench supplies the shared clock to both ends.
`timescale 1ns/10ps
`default_nettype none
interface flash_link_if;
    logic cs_n;
    logic sclk;
    logic si;
    logic so;
    logic so_oe_n;
    logic [2:0] upper_serial_lines;

    modport ctrl (
        output cs_n, sclk, si, upper_serial_lines,
        input so, so_oe_n
    );
    modport flash (
        input cs_n, sclk, si, upper_serial_lines,
        output so, so_oe_n
    );
endinterface
`default_nettype wire

//--- rtl/flash_cmd_slice.sv
// Flash end: decodes reset arm/execute, no-op, unique-ID read and
// parameter-table read from the serial link (mode 0, MSB first).
// Assumes link signals come from logic on mclk_i, so no synchronisers.
// Operation
// - Soft reset is arm then execute
// - Completed reset returns device to standby
// - Reset clears all volatile state
// - Execute ignored unless arm accepted first
// - Any other command cancels armed state
// - Reset aborts running program or erase
// - No-op only cancels pending arm
// - Arm and execute accepted at any time
// - Read-only unique 128-bit identifier
// - Unique-ID: opcode, four dummies, 128 bits out
// - Table read: opcode then three address bytes
// - One dummy byte before table data
// - Table streams until chip select rises
// - Only lowest address byte selects location
// - Locations 0-3 hold signature bytes
// - Minor revision 00, major revision 01
// - Header count 01 means two headers
// - Locations 07, 0F, 17 read FF
// - First header ID and revisions fixed
// - First header length 09, pointer 30
// - Second header manufacturer code, revisions
// - Second header length 03, pointer 90
`timescale 1ns/10ps
`default_nettype none
module flash_cmd_slice #(
    parameter logic [127:0] UNIQUE_ID = flash_cmd_pkg::UNIQUE_ID_DEFAULT,
    parameter logic [7:0] MFR_CODE = flash_cmd_pkg::MFR_CODE_DEFAULT
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    flash_link_if.flash link,
    input wire logic busy_i,
    output logic soft_reset_o,
    output logic abort_o,
    output logic standby_o,
    output logic armed_o
);

    flash_cmd_pkg::dev_state_t state_r, state_nxt;
    logic [2:0] bit_r, bit_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    logic [7:0] in_r, in_nxt;
    logic [7:0] out_r, out_nxt;
    logic [7:0] idx_r, idx_nxt;
    logic [7:0] addr_r, addr_nxt;
    logic tbl_r, tbl_nxt;
    logic armed_r, armed_nxt;
    logic so_r, so_nxt;
    logic rst_r, rst_nxt;
    logic abort_r, abort_nxt;
    logic standby_r, standby_nxt;
    logic sclk_d_r;
    logic sclk_rise, sclk_fall, out_phase;
    logic [7:0] byte_in, cur_byte, tbl_byte, uid_byte;
    logic [6:0] uid_base;

    assign sclk_rise = link.sclk & ~sclk_d_r;
    assign sclk_fall = ~link.sclk & sclk_d_r;
    assign out_phase = (state_r == flash_cmd_pkg::DS_UID) || (state_r == flash_cmd_pkg::DS_TABLE);
    assign byte_in = {in_r[6:0], link.si};

    // The identifier is a parameter, so nothing on the link can change it
    assign uid_base = 7'(flash_cmd_pkg::UID_BITS - 1) - {idx_r[3:0], 3'b000};
    assign uid_byte = UNIQUE_ID[uid_base -: 8];

    always_comb
    begin
        tbl_byte = flash_cmd_pkg::TBL_BLANK;
        if (idx_r == flash_cmd_pkg::TBL_MFR_LOC)
        begin
            tbl_byte = MFR_CODE;
        end
        else if (idx_r < 8'(flash_cmd_pkg::TBL_BYTES))
        begin
            tbl_byte = flash_cmd_pkg::TBL_ROM[idx_r[4:0]];
        end
    end

    assign cur_byte = tbl_r ? tbl_byte : uid_byte;

    always_comb
    begin
        state_nxt = state_r;
        bit_nxt = bit_r;
        cnt_nxt = cnt_r;
        in_nxt = in_r;
        out_nxt = out_r;
        idx_nxt = idx_r;
        addr_nxt = addr_r;
        tbl_nxt = tbl_r;
        armed_nxt = armed_r;
        so_nxt = so_r;
        rst_nxt = 1'b0;
        abort_nxt = 1'b0;
        standby_nxt = link.cs_n;
        if (link.cs_n)
        begin
            // Select high ends any frame and drops a half-received opcode
            state_nxt = flash_cmd_pkg::DS_OPCODE;
            bit_nxt = 3'b000;
        end
        else if (sclk_rise && !out_phase && state_r != flash_cmd_pkg::DS_SKIP)
        begin
            in_nxt = byte_in;
            bit_nxt = bit_r + 3'b001;
            if (bit_r == 3'b111)
            begin
                case (state_r)
                    flash_cmd_pkg::DS_OPCODE:
                    begin
                        state_nxt = flash_cmd_pkg::DS_SKIP;
                        armed_nxt = 1'b0;
                        case (byte_in)
                            flash_cmd_pkg::OP_RESET_ARM:
                            begin
                                armed_nxt = 1'b1;
                            end
                            flash_cmd_pkg::OP_RESET_EXEC:
                            begin
                                // Execute without a prior arm falls through silently
                                rst_nxt = armed_r;
                                abort_nxt = armed_r & busy_i;
                            end
                            flash_cmd_pkg::OP_NOP:
                            begin
                                armed_nxt = 1'b0;
                            end
                            flash_cmd_pkg::OP_UID_READ:
                            begin
                                state_nxt = flash_cmd_pkg::DS_DUMMY;
                                cnt_nxt = 3'(flash_cmd_pkg::UID_DUMMY_BYTES);
                                tbl_nxt = 1'b0;
                            end
                            flash_cmd_pkg::OP_TABLE_READ:
                            begin
                                state_nxt = flash_cmd_pkg::DS_ADDR;
                                cnt_nxt = 3'(flash_cmd_pkg::TBL_ADDR_BYTES);
                                tbl_nxt = 1'b1;
                            end
                            default:
                            begin
                                armed_nxt = 1'b0;
                            end
                        endcase
                    end
                    flash_cmd_pkg::DS_ADDR:
                    begin
                        // Each address byte overwrites the last, leaving only the lowest
                        addr_nxt = byte_in;
                        cnt_nxt = cnt_r - 3'b001;
                        if (cnt_r == 3'b001)
                        begin
                            state_nxt = flash_cmd_pkg::DS_DUMMY;
                            cnt_nxt = 3'(flash_cmd_pkg::TBL_DUMMY_BYTES);
                        end
                    end
                    flash_cmd_pkg::DS_DUMMY:
                    begin
                        cnt_nxt = cnt_r - 3'b001;
                        if (cnt_r == 3'b001)
                        begin
                            state_nxt = tbl_r ? flash_cmd_pkg::DS_TABLE : flash_cmd_pkg::DS_UID;
                            idx_nxt = tbl_r ? addr_r : 8'h00;
                        end
                    end
                    default:
                    begin
                        state_nxt = flash_cmd_pkg::DS_SKIP;
                    end
                endcase
            end
        end
        else if (sclk_fall && out_phase)
        begin
            // Data moves on the falling edge so it is stable at the host's rising edge
            bit_nxt = bit_r + 3'b001;
            if (bit_r == 3'b000)
            begin
                so_nxt = cur_byte[7];
                out_nxt = {cur_byte[6:0], 1'b0};
                idx_nxt = idx_r + 8'h01;
            end
            else
            begin
                so_nxt = out_r[7];
                out_nxt = {out_r[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state_r <= flash_cmd_pkg::DS_OPCODE;
            bit_r <= 3'b000;
            cnt_r <= 3'b000;
            in_r <= 8'h00;
            out_r <= 8'h00;
            idx_r <= 8'h00;
            addr_r <= 8'h00;
            tbl_r <= 1'b0;
            armed_r <= 1'b0;
            so_r <= 1'b0;
            rst_r <= 1'b0;
            abort_r <= 1'b0;
            standby_r <= 1'b1;
            sclk_d_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            bit_r <= bit_nxt;
            cnt_r <= cnt_nxt;
            in_r <= in_nxt;
            out_r <= out_nxt;
            idx_r <= idx_nxt;
            addr_r <= addr_nxt;
            tbl_r <= tbl_nxt;
            armed_r <= armed_nxt;
            so_r <= so_nxt;
            rst_r <= rst_nxt;
            abort_r <= abort_nxt;
            standby_r <= standby_nxt;
            sclk_d_r <= link.sclk;
        end
    end

    // Only the primary output line is driven; the upper lines are never read
    assign link.so = so_r;
    assign link.so_oe_n = ~(out_phase & ~link.cs_n);
    assign soft_reset_o = rst_r;
    assign abort_o = abort_r;
    assign standby_o = standby_r;
    assign armed_o = armed_r;

endmodule // flash_cmd_slice
`default_nettype wire

//--- rtl/flash_cmd_ctrl.sv
// Controller end: turns user commands into serial frames and returns
// read bytes through a small buffer that stalls the serial clock when full.
// Assumes the flash end shares mclk_i.
`timescale 1ns/10ps
`default_nettype none
module flash_cmd_ctrl #(
    parameter int HALF_CYC = flash_cmd_pkg::SCLK_HALF_CYC,
    parameter int GAP_CYC = flash_cmd_pkg::CS_GAP_CYC,
    parameter int DEPTH = 2
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    flash_link_if.ctrl link,
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire logic [7:0] cmd_op_i,
    input wire logic [23:0] cmd_addr_i,
    input wire logic [7:0] cmd_len_i,
    output logic rd_valid_o,
    input wire logic rd_ready_i,
    output logic [7:0] rd_data_o,
    output logic done_o
);

    localparam int PW = $clog2(DEPTH);

    flash_cmd_pkg::host_state_t st_r, st_nxt;
    logic [7:0] div_r, div_nxt;
    logic [7:0] gap_r, gap_nxt;
    logic sclk_r, sclk_nxt;
    logic cs_n_r, cs_n_nxt;
    logic [39:0] tx_r, tx_nxt;
    logic [2:0] txl_r, txl_nxt;
    logic [7:0] rxl_r, rxl_nxt;
    logic [2:0] bit_r, bit_nxt;
    logic [7:0] rx_r, rx_nxt;
    logic exec_r, exec_nxt;
    logic done_r, done_nxt;
    logic [7:0] mem_r [0:DEPTH-1];
    logic [7:0] mem_nxt [0:DEPTH-1];
    logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [PW:0] cnt_r, cnt_nxt;
    logic full, push, pop, rx_phase, tick;
    logic [7:0] op_send;

    assign full = (cnt_r == (PW + 1)'(DEPTH));
    assign rx_phase = (txl_r == 3'b000);
    assign tick = (div_r == 8'(HALF_CYC - 1));
    assign pop = rd_valid_o & rd_ready_i;
    // Execute is always preceded by its own arm frame
    assign op_send = (cmd_op_i == flash_cmd_pkg::OP_RESET_EXEC) ? flash_cmd_pkg::OP_RESET_ARM
                                                                : cmd_op_i;

    always_comb
    begin
        st_nxt = st_r;
        div_nxt = div_r;
        gap_nxt = gap_r;
        sclk_nxt = sclk_r;
        cs_n_nxt = cs_n_r;
        tx_nxt = tx_r;
        txl_nxt = txl_r;
        rxl_nxt = rxl_r;
        bit_nxt = bit_r;
        rx_nxt = rx_r;
        exec_nxt = exec_r;
        done_nxt = 1'b0;
        push = 1'b0;
        case (st_r)
            flash_cmd_pkg::HS_IDLE:
            begin
                if (cmd_valid_i)
                begin
                    st_nxt = flash_cmd_pkg::HS_FRAME;
                    cs_n_nxt = 1'b0;
                    div_nxt = 8'h00;
                    bit_nxt = 3'b000;
                    exec_nxt = (cmd_op_i == flash_cmd_pkg::OP_RESET_EXEC);
                    tx_nxt = {op_send, 32'h0000_0000};
                    txl_nxt = 3'b001;
                    rxl_nxt = 8'h00;
                    if (cmd_op_i == flash_cmd_pkg::OP_UID_READ)
                    begin
                        txl_nxt = 3'(1 + flash_cmd_pkg::UID_DUMMY_BYTES);
                        rxl_nxt = cmd_len_i;
                    end
                    else if (cmd_op_i == flash_cmd_pkg::OP_TABLE_READ)
                    begin
                        tx_nxt = {op_send, cmd_addr_i, 8'h00};
                        txl_nxt = 3'(1 + flash_cmd_pkg::TBL_ADDR_BYTES
                                      + flash_cmd_pkg::TBL_DUMMY_BYTES);
                        rxl_nxt = cmd_len_i;
                    end
                end
            end
            flash_cmd_pkg::HS_FRAME:
            begin
                // Clock holds low in the read phase while the buffer is full, so no byte is lost
                if (!(rx_phase && full && !sclk_r))
                begin
                    div_nxt = tick ? 8'h00 : div_r + 8'h01;
                    if (tick && !sclk_r)
                    begin
                        sclk_nxt = 1'b1;
                        if (rx_phase)
                        begin
                            rx_nxt = {rx_r[6:0], link.so};
                            push = (bit_r == 3'b111);
                        end
                    end
                    else if (tick)
                    begin
                        sclk_nxt = 1'b0;
                        bit_nxt = bit_r + 3'b001;
                        if (!rx_phase)
                        begin
                            tx_nxt = {tx_r[38:0], 1'b0};
                        end
                        if (bit_r == 3'b111)
                        begin
                            if (!rx_phase)
                            begin
                                txl_nxt = txl_r - 3'b001;
                            end
                            else
                            begin
                                rxl_nxt = rxl_r - 8'h01;
                            end
                            if ((txl_r == 3'b001 && rxl_r == 8'h00) ||
                                (rx_phase && rxl_r == 8'h01))
                            begin
                                st_nxt = flash_cmd_pkg::HS_GAP;
                                cs_n_nxt = 1'b1;
                                gap_nxt = 8'h00;
                            end
                        end
                    end
                end
            end
            flash_cmd_pkg::HS_GAP:
            begin
                gap_nxt = gap_r + 8'h01;
                if (gap_r >= 8'(GAP_CYC - 1))
                begin
                    if (exec_r)
                    begin
                        st_nxt = flash_cmd_pkg::HS_FRAME;
                        cs_n_nxt = 1'b0;
                        div_nxt = 8'h00;
                        exec_nxt = 1'b0;
                        tx_nxt = {flash_cmd_pkg::OP_RESET_EXEC, 32'h0000_0000};
                        txl_nxt = 3'b001;
                        rxl_nxt = 8'h00;
                    end
                    else
                    begin
                        st_nxt = flash_cmd_pkg::HS_IDLE;
                        done_nxt = 1'b1;
                    end
                end
            end
            default:
            begin
                st_nxt = flash_cmd_pkg::HS_IDLE;
            end
        endcase
    end

    always_comb
    begin
        mem_nxt = mem_r;
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        if (push)
        begin
            mem_nxt[wp_r] = {rx_r[6:0], link.so};
            wp_nxt = wp_r + 1'b1;
        end
        if (pop)
        begin
            rp_nxt = rp_r + 1'b1;
        end
        cnt_nxt = cnt_r + (PW + 1)'(push) - (PW + 1)'(pop);
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st_r <= flash_cmd_pkg::HS_IDLE;
            div_r <= 8'h00;
            gap_r <= 8'h00;
            sclk_r <= 1'b0;
            cs_n_r <= 1'b1;
            tx_r <= 40'h00_0000_0000;
            txl_r <= 3'b000;
            rxl_r <= 8'h00;
            bit_r <= 3'b000;
            rx_r <= 8'h00;
            exec_r <= 1'b0;
            done_r <= 1'b0;
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            for (int i = 0; i < DEPTH; i++)
            begin
                mem_r[i] <= 8'h00;
            end
        end
        else
        begin
            st_r <= st_nxt;
            div_r <= div_nxt;
            gap_r <= gap_nxt;
            sclk_r <= sclk_nxt;
            cs_n_r <= cs_n_nxt;
            tx_r <= tx_nxt;
            txl_r <= txl_nxt;
            rxl_r <= rxl_nxt;
            bit_r <= bit_nxt;
            rx_r <= rx_nxt;
            exec_r <= exec_nxt;
            done_r <= done_nxt;
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
            mem_r <= mem_nxt;
        end
    end

    assign link.cs_n = cs_n_r;
    assign link.sclk = sclk_r;
    assign link.si = tx_r[39];
    assign link.upper_serial_lines = 3'b000;
    assign cmd_ready_o = (st_r == flash_cmd_pkg::HS_IDLE);
    assign rd_valid_o = (cnt_r != '0);
    assign rd_data_o = mem_r[rp_r];
    assign done_o = done_r;

endmodule // flash_cmd_ctrl
`default_nettype wire

//--- tb/flash_cmd_props.sv
// Link checker: watches the serial link between controller and slice.
// Assumes all link signals are sampled on the shared mclk_i.
`timescale 1ns/10ps
`default_nettype none
module flash_cmd_props (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe_n,
    input wire logic [2:0] upper_serial_lines
);
    logic sclk_q_r;
    logic [7:0] rise_cnt_r;
    logic [7:0] rise_cnt_nxt;

    // Rises seen in the current frame; a frame must carry whole bytes
    always_comb
    begin
        rise_cnt_nxt = rise_cnt_r;
        if (cs_n)
        begin
            rise_cnt_nxt = 8'h00;
        end
        else if (sclk && !sclk_q_r)
        begin
            rise_cnt_nxt = rise_cnt_r + 8'h01;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sclk_q_r <= 1'b0;
            rise_cnt_r <= 8'h00;
        end
        else
        begin
            sclk_q_r <= sclk;
            rise_cnt_r <= rise_cnt_nxt;
        end
    end

    default clocking dc @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    AST_OE_IDLE: assert property (cs_n |-> so_oe_n)
        else $error("so driven while deselected");
    AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
        else $error("sclk not low outside a frame");
    AST_UPPER_LINES: assert property (upper_serial_lines == 3'h0)
        else $error("upper serial lines not quiet");
    AST_SCLK_HIGH: assert property ($rose(sclk) |-> ##1 sclk ##1 !sclk)
        else $error("sclk high phase not two cycles");
    AST_SI_HOLD: assert property (sclk && $past(sclk) |-> $stable(si))
        else $error("si moved while sclk high");
    AST_SO_HOLD: assert property (!cs_n && sclk |-> $stable(so))
        else $error("so moved while sclk high");
    AST_OE_START: assert property ($fell(so_oe_n) |-> !cs_n && sclk ##1 !sclk)
        else $error("so enabled outside the last dummy high phase");
    AST_FRAME_BYTES: assert property ($rose(cs_n) |-> rise_cnt_r[2:0] == 3'h0)
        else $error("frame ended inside a byte");
    AST_CS_SETUP: assert property ($fell(cs_n) |-> !sclk ##1 !sclk)
        else $error("sclk rose too soon after select");
endmodule // flash_cmd_props
`default_nettype wire

//--- tb/flash_reset_uid_sfdp_cmds_tb.sv
// Bench: controller and command slice joined by the link interface.
// Assumes ctrl defaults HALF_CYC=2, GAP_CYC=2, DEPTH=2.
`timescale 1ns/10ps
`default_nettype none
module flash_reset_uid_sfdp_cmds_tb;
    localparam logic [127:0] UID = 128'h3C5A9E017788F00D12345678C0DEABCD; // Arbitrary value
    localparam logic [7:0] MFR = 8'h3C; // Arbitrary value
    localparam logic [191:0] TBL = {64'h53464450000101FF, 64'h00000109300000FF, MFR,
        56'h000103900000FF};
    logic mclk_i;
    logic resetn_i;
    logic busy, cmd_valid, cmd_ready, rd_valid, rd_ready, done;
    logic soft_reset, abort, standby, armed;
    logic [7:0] cmd_op, cmd_len, rd_data;
    logic [23:0] cmd_addr;
    logic [7:0] got[$];
    bit done_seen;
    int err_count, check_count, rst_cnt, abort_cnt;

    flash_link_if link ();
    flash_cmd_slice #(.UNIQUE_ID(UID), .MFR_CODE(MFR)) i_flash_cmd_slice (.mclk_i(mclk_i),
        .resetn_i(resetn_i), .link(link), .busy_i(busy), .soft_reset_o(soft_reset),
        .abort_o(abort), .standby_o(standby), .armed_o(armed));
    flash_cmd_ctrl i_flash_cmd_ctrl (.mclk_i(mclk_i), .resetn_i(resetn_i), .link(link),
        .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_op_i(cmd_op),
        .cmd_addr_i(cmd_addr), .cmd_len_i(cmd_len), .rd_valid_o(rd_valid),
        .rd_ready_i(rd_ready), .rd_data_o(rd_data), .done_o(done));
    flash_cmd_props i_flash_cmd_props (.mclk_i(mclk_i), .resetn_i(resetn_i),
        .cs_n(link.cs_n), .sclk(link.sclk), .si(link.si), .so(link.so),
        .so_oe_n(link.so_oe_n), .upper_serial_lines(link.upper_serial_lines));

    initial mclk_i = 1'b0;
    always #20 mclk_i = ~mclk_i;

    always @(posedge mclk_i)
    begin
        if (rd_valid === 1'b1 && rd_ready === 1'b1)
            got.push_back(rd_data);
        if (done === 1'b1)
            done_seen = 1'b1;
        if (soft_reset === 1'b1)
            rst_cnt++;
        if (abort === 1'b1)
            abort_cnt++;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Slow mode pops once in 64 cycles, slower than bytes arrive, so sclk stalls
    task automatic run_cmd(input logic [7:0] op, input logic [23:0] addr,
        input logic [7:0] len, input bit slow);
        int n;
        @(negedge mclk_i);
        got.delete();
        done_seen = 1'b0;
        cmd_op = op;
        cmd_addr = addr;
        cmd_len = len;
        check("cmd_ready", cmd_ready, 1'b1);
        cmd_valid = 1'b1;
        @(negedge mclk_i);
        cmd_valid = 1'b0;
        @(negedge mclk_i);
        check("cmd_ready", cmd_ready, 1'b0);
        check("standby", standby, 1'b0);
        for (n = 0; n < 30000 && !done_seen; n++)
        begin
            @(negedge mclk_i);
            rd_ready = !slow || (n % 64 == 0);
        end
        if (!done_seen)
        begin
            err_count++;
            finish_test();
        end
        else
        begin
            rd_ready = 1'b1;
            repeat (4) @(negedge mclk_i);
            check("byte count", got.size(), len);
        end
    endtask

    initial
    begin
        resetn_i = 1'b0;
        busy = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = 8'h00;
        cmd_addr = 24'h000000;
        cmd_len = 8'h00;
        rd_ready = 1'b1;
        repeat (16) @(negedge mclk_i);
        resetn_i = 1'b1;
        @(negedge mclk_i);
        check("armed", armed, 1'b0);
        check("standby", standby, 1'b1);
        check("rd_valid", rd_valid, 1'b0);
        run_cmd(flash_cmd_pkg::OP_RESET_ARM, 24'h000000, 8'h00, 1'b0);
        check("armed", armed, 1'b1);
        run_cmd(flash_cmd_pkg::OP_NOP, 24'h000000, 8'h00, 1'b0);
        check("armed", armed, 1'b0);
        check("resets", rst_cnt, 0);
        run_cmd(flash_cmd_pkg::OP_RESET_ARM, 24'h000000, 8'h00, 1'b0);
        run_cmd(8'hC3, 24'h000000, 8'h00, 1'b0);
        check("armed", armed, 1'b0);
        run_cmd(flash_cmd_pkg::OP_RESET_ARM, 24'h000000, 8'h00, 1'b0);
        run_cmd(flash_cmd_pkg::OP_UID_READ, 24'h000000, 8'h10, 1'b1);
        check("armed", armed, 1'b0);
        for (int i = 0; i < 16; i++)
            check("uid byte", got[i], UID[127-8*i -: 8]);
        busy = 1'b1;
        run_cmd(flash_cmd_pkg::OP_RESET_ARM, 24'h000000, 8'h00, 1'b0);
        check("armed", armed, 1'b1);
        run_cmd(flash_cmd_pkg::OP_RESET_EXEC, 24'h000000, 8'h00, 1'b0);
        check("resets", rst_cnt, 1);
        check("aborts", abort_cnt, 1);
        check("armed", armed, 1'b0);
        busy = 1'b0;
        run_cmd(flash_cmd_pkg::OP_RESET_EXEC, 24'h000000, 8'h00, 1'b0);
        check("resets", rst_cnt, 2);
        check("aborts", abort_cnt, 1);
        check("standby", standby, 1'b1);
        run_cmd(flash_cmd_pkg::OP_TABLE_READ, 24'hABCD00, 8'h1A, 1'b1);
        for (int i = 0; i < 26; i++)
            check("table byte", got[i], (i < 24) ? TBL[191-8*i -: 8] : 8'hFF);
        run_cmd(flash_cmd_pkg::OP_TABLE_READ, 24'h3C3C10, 8'h02, 1'b0);
        check("maker byte", got[0], MFR);
        check("minor rev", got[1], 8'h00);
        finish_test();
    end
endmodule // flash_reset_uid_sfdp_cmds_tb
`default_nettype wire
